//--- logic/gcs_pkg.sv
/*
  gcs_pkg: register map, field positions, reset values and source codes
  for the global clock select and gate block.
  assumes: a 32-bit AXI4-Lite register bus; nothing else shares these names.
*/
package gcs_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [31:0] GCS_CFG_OFS  = 32'h0000_0000;
  localparam logic [31:0] GCS_STAT_OFS = 32'h0000_0004;
  localparam logic [31:0] GCS_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] GCS_ADDR_MSK = 32'h0000_0FFC;

  // ************************************************************
  // configuration word fields
  // ************************************************************
  localparam int GCS_CFG_DONE_BIT = 0;  // static selection is set
  localparam int GCS_CFG_MODE_LSB = 1;  // two bits, static source class
  localparam int GCS_CFG_PD_BIT   = 3;  // static power down
  localparam int GCS_CFG_DP_LSB   = 4;  // two bits, dual-purpose pin choice
  localparam int GCS_CFG_PAIR_BIT = 6;  // which adjacent pll pair
  localparam int GCS_CFG_WIDTH    = 7;

  // ************************************************************
  // status word fields
  // ************************************************************
  localparam int GCS_ST_NET_GATE_BIT = 0;
  localparam int GCS_ST_PIN_GATE_BIT = 1;
  localparam int GCS_ST_SEL_LSB      = 2;  // two bits
  localparam int GCS_ST_PLL_OK_BIT   = 4;
  localparam int GCS_ST_NET_BIT      = 5;

  // ************************************************************
  // source classes and dynamic select codes
  // ************************************************************
  typedef enum logic [1:0] {
    GCS_MODE_DYNAMIC  = 2'b00,
    GCS_MODE_DUAL_PIN = 2'b01,
    GCS_MODE_INTERNAL = 2'b10,
    GCS_MODE_OFF      = 2'b11
  } gcs_mode_t;

  typedef enum logic [1:0] {
    GCS_SEL_PIN0 = 2'b00,
    GCS_SEL_PIN1 = 2'b01,
    GCS_SEL_PLLA = 2'b10,
    GCS_SEL_PLLB = 2'b11
  } gcs_sel_t;

  typedef enum logic [1:0] {
    GCS_DP_PLAIN   = 2'b00,
    GCS_DP_CORNER0 = 2'b01,
    GCS_DP_CORNER1 = 2'b10,
    GCS_DP_NONE    = 2'b11
  } gcs_dp_t;

  localparam int GCS_DED_PINS    = 2;
  localparam int GCS_PLL_TAPS    = 4;
  localparam int GCS_CORNER_PINS = 2;
  localparam int GCS_NET_STAGES  = 1;
  localparam int GCS_PIN_STAGES  = 2;

endpackage : gcs_pkg

//--- logic/gcs_gate.sv
/*
  gcs_gate: clock gate for one sampled clock source.
  the enable is shifted through STAGES registers, one step per falling
  edge of the source, and the gated level is registered.
  assumes: src_lvl already synchronised to clk, fall is its falling edge.
*/
`timescale 1ns/10ps
`default_nettype none

module gcs_gate #(
  parameter int STAGES = 1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // source and request
  input  wire logic src_lvl,
  input  wire logic fall,
  input  wire logic gate_req,
  // results
  output logic      gate_on,
  output logic      out_q
);

  typedef struct packed {
    logic [STAGES-1:0] stg;
    logic              out;
  } gcs_gate_st_t;

  gcs_gate_st_t st_q;
  gcs_gate_st_t st_d;

  // ************************************************************
  // gate chain
  // ************************************************************
  // enable only moves while the source is low, so no pulse is cut short
  always_comb
  begin
    st_d = st_q;
    if (fall)
    begin
      // shift up and insert at bit 0; no part-select, so one stage is legal too
      st_d.stg    = st_q.stg << 1;
      st_d.stg[0] = gate_req;
    end
    st_d.out = src_lvl & st_q.stg[STAGES-1];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign gate_on = st_q.stg[STAGES-1];
  assign out_q   = st_q.out;

endmodule // gcs_gate

`default_nettype wire

//--- logic/gcs_top.sv
/*
  gcs_top: one clock control block. picks a source for the global network,
  gates it, gates the first pll output towards its pin, and carries an
  AXI4-Lite register slave for the static configuration.
  assumes: clk at 100 MHz; all candidate sources are slower than clk/4 so
  that sampling sees every level; fabric select and gate come from clk logic.
*/
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - six candidate inputs, pll pair from four
// - pins and pll outputs selectable at run time
// - internal logic only by static selection
// - larger variant source pool per side
// - basic variant source pool per side
// - one corner dual-purpose pin at once
// - one network per block
// - five blocks on each side
// - static power down by configuration
// - fabric enables or disables network dynamically
// - disabled network stops all its logic
// - gating leaves pll untouched, no relock
// - gate sampled on source falling edge
// - one stage network, two stages pin
// - gate holds outputs off during resync
// - dual-purpose or internal source blocks pll
module gcs_top (
  // clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  // candidate sources
  input  wire logic [gcs_pkg::GCS_DED_PINS-1:0]      ded_clk_pin,
  input  wire logic [gcs_pkg::GCS_PLL_TAPS-1:0]      pll_out,
  input  wire logic                                  dual_purpose_clock_pin,
  input  wire logic [gcs_pkg::GCS_CORNER_PINS-1:0]   corner_dual_purpose_clock_pin,
  input  wire logic                                  internal_logic_src,
  // fabric controls
  input  wire logic [1:0]                            clk_select,
  input  wire logic                                  net_gate_en,
  input  wire logic                                  pin_gate_en,
  // outputs
  output logic                                       global_clock_net,  // one net, replicated above
  output logic                                       pll_output_zero_pin,
  output logic                                       pll_input_ok,
  // axi4-lite write address
  input  wire logic [31:0]                           s_axi_awaddr,
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                                 s_axi_bresp,
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0]                           s_axi_araddr,
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready
);
  import gcs_pkg::*;

  localparam int SYNC_W = GCS_DED_PINS + GCS_PLL_TAPS + 1 + GCS_CORNER_PINS;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [SYNC_W-1:0]        sync1;
    logic [SYNC_W-1:0]        sync2;
    logic                     net_src_prev;
    logic                     pin_src_prev;
    logic [GCS_CFG_WIDTH-1:0] cfg;
    logic                     aw_have;
    logic [31:0]              aw_addr;
    logic                     w_have;
    logic [31:0]              w_data;
    logic [3:0]               w_strb;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [1:0]               rresp;
    logic [31:0]              rdata;
  } gcs_st_t;

  gcs_st_t st_q;
  gcs_st_t st_d;

  // ************************************************************
  // decoded sources
  // ************************************************************
  logic [GCS_DED_PINS-1:0]    ded_s;
  logic [GCS_PLL_TAPS-1:0]    pll_s;
  logic                       dp_s;
  logic [GCS_CORNER_PINS-1:0] cdp_s;
  logic [1:0]                 pll_pair;
  gcs_mode_t                  mode;
  gcs_dp_t                    dp_choice;
  logic                       cfg_done;
  logic                       cfg_pd;
  logic                       net_src;
  logic                       net_fall;
  logic                       pin_fall;
  logic                       net_gate_on;
  logic                       pin_gate_on;
  logic                       net_out;
  logic                       pin_out;
  logic                       net_allowed;
  logic [31:0]                status;

  // second sync stage only; first stage feeds nothing else
  assign ded_s = st_q.sync2[GCS_DED_PINS-1:0];
  assign pll_s = st_q.sync2[GCS_DED_PINS +: GCS_PLL_TAPS];
  assign dp_s  = st_q.sync2[GCS_DED_PINS + GCS_PLL_TAPS];
  assign cdp_s = st_q.sync2[SYNC_W-1 -: GCS_CORNER_PINS];

  // two of the four adjacent pll taps reach this block
  assign pll_pair  = st_q.cfg[GCS_CFG_PAIR_BIT] ? pll_s[3:2] : pll_s[1:0];
  assign mode      = gcs_mode_t'(st_q.cfg[GCS_CFG_MODE_LSB +: 2]);
  assign dp_choice = gcs_dp_t'(st_q.cfg[GCS_CFG_DP_LSB +: 2]);
  assign cfg_done  = st_q.cfg[GCS_CFG_DONE_BIT];
  assign cfg_pd    = st_q.cfg[GCS_CFG_PD_BIT];

  // ************************************************************
  // source selection
  // ************************************************************
  // internal logic is reachable only through the static mode field
  always_comb
  begin
    net_src = 1'b0;
    unique case (mode)
      GCS_MODE_DYNAMIC:
      begin
        unique case (gcs_sel_t'(clk_select))
          GCS_SEL_PIN0: net_src = ded_s[0];
          GCS_SEL_PIN1: net_src = ded_s[1];
          GCS_SEL_PLLA: net_src = pll_pair[0];
          GCS_SEL_PLLB: net_src = pll_pair[1];
        endcase
      end
      GCS_MODE_DUAL_PIN:
      begin
        unique case (dp_choice)
          GCS_DP_PLAIN:   net_src = dp_s;
          GCS_DP_CORNER0: net_src = cdp_s[0];
          GCS_DP_CORNER1: net_src = cdp_s[1];
          GCS_DP_NONE:    net_src = 1'b0;
        endcase
      end
      GCS_MODE_INTERNAL: net_src = internal_logic_src;
      GCS_MODE_OFF:      net_src = 1'b0;
    endcase
  end

  // network runs only once configured and not statically powered down
  assign net_allowed = cfg_done & ~cfg_pd;
  assign net_fall    = st_q.net_src_prev & ~net_src;
  assign pin_fall    = st_q.pin_src_prev & ~pll_pair[0];
  // pll input only from pins or another pll, never dual-purpose/internal
  assign pll_input_ok = cfg_done & (mode == GCS_MODE_DYNAMIC);

  // ************************************************************
  // gates
  // ************************************************************
  // gates act after the mux, the pll taps themselves keep running
  gcs_gate #(
    .STAGES (GCS_NET_STAGES)
  ) u_net_gate (
    .clk      (clk),
    .rst      (rst),
    .src_lvl  (net_src & net_allowed),
    .fall     (net_fall),
    .gate_req (net_gate_en & net_allowed),
    .gate_on  (net_gate_on),
    .out_q    (net_out)
  );

  gcs_gate #(
    .STAGES (GCS_PIN_STAGES)
  ) u_pin_gate (
    .clk      (clk),
    .rst      (rst),
    .src_lvl  (pll_pair[0]),
    .fall     (pin_fall),
    .gate_req (pin_gate_en),
    .gate_on  (pin_gate_on),
    .out_q    (pin_out)
  );

  assign global_clock_net    = net_out;
  assign pll_output_zero_pin = pin_out;

  // ************************************************************
  // status word
  // ************************************************************
  always_comb
  begin
    status = 32'h0000_0000;
    status[GCS_ST_NET_GATE_BIT]  = net_gate_on;
    status[GCS_ST_PIN_GATE_BIT]  = pin_gate_on;
    status[GCS_ST_SEL_LSB +: 2]  = clk_select;
    status[GCS_ST_PLL_OK_BIT]    = pll_input_ok;
    status[GCS_ST_NET_BIT]       = net_out;
  end

  // ************************************************************
  // next state: synchronisers, edge history and bus slave
  // ************************************************************
  // one write and one read in flight; aw and w may arrive in either order
  always_comb
  begin
    st_d = st_q;
    st_d.sync1        = {corner_dual_purpose_clock_pin, dual_purpose_clock_pin, pll_out, ded_clk_pin};
    st_d.sync2        = st_q.sync1;
    st_d.net_src_prev = net_src;
    st_d.pin_src_prev = pll_pair[0];

    if (s_axi_awvalid && s_axi_awready)
    begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_d.w_have = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.aw_have && st_q.w_have)
    begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = RESP_OKAY;
      if ((st_q.aw_addr & GCS_ADDR_MSK) == GCS_CFG_OFS)
      begin
        // only lane 0 carries configuration bits
        if (st_q.w_strb[0])
          st_d.cfg = st_q.w_data[GCS_CFG_WIDTH-1:0];
      end
      else if ((st_q.aw_addr & GCS_ADDR_MSK) != GCS_STAT_OFS)
        st_d.bresp = RESP_SLVERR;
    end
    if (st_q.bvalid && s_axi_bready)
      st_d.bvalid = 1'b0;

    if (s_axi_arvalid && s_axi_arready)
    begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = RESP_OKAY;
      st_d.rdata  = 32'h0000_0000;
      if ((s_axi_araddr & GCS_ADDR_MSK) == GCS_CFG_OFS)
        st_d.rdata[GCS_CFG_WIDTH-1:0] = st_q.cfg;
      else if ((s_axi_araddr & GCS_ADDR_MSK) == GCS_STAT_OFS)
        st_d.rdata = status;
      else
        st_d.rresp = RESP_SLVERR;
    end
    else if (st_q.rvalid && s_axi_rready)
      st_d.rvalid = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q     <= '0;
      st_q.cfg <= GCS_CFG_RST[GCS_CFG_WIDTH-1:0];
    end
    else
      st_q <= st_d;
  end

  // handshake outputs are combinational on registered state
  assign s_axi_awready = ~st_q.aw_have & ~st_q.bvalid;
  assign s_axi_wready  = ~st_q.w_have & ~st_q.bvalid;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = ~st_q.rvalid;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rresp   = st_q.rresp;
  assign s_axi_rdata   = st_q.rdata;

endmodule // gcs_top

`default_nettype wire

//--- dv/gcs_properties.sv
/*
  gcs_properties: concurrent checks on the ports of gcs_top.
  assumes: bound to gcs_top, sources slower than five clk cycles per level.
*/
`timescale 1ns/10ps
`default_nettype none

module gcs_properties (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // clock paths
  input wire logic        global_clock_net,
  input wire logic        pll_output_zero_pin,
  input wire logic        net_gate_en,
  input wire logic        pin_gate_en,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // ************************************************************
  // helpers and properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  typedef struct packed {
    logic [6:0] net_off;
    logic [6:0] pin_off;
  } gcs_chk_t;
  gcs_chk_t s_q;
  gcs_chk_t s_d;
  // saturating count of cycles each request has been low
  always_comb
  begin
    s_d = s_q;
    s_d.net_off = net_gate_en ? 7'h0 : s_q.net_off + 7'(s_q.net_off != 7'h7f);
    s_d.pin_off = pin_gate_en ? 7'h0 : s_q.pin_off + 7'(s_q.pin_off != 7'h7f);
  end
  // helper state
  always_ff @(posedge clk)
  begin
    s_q <= rst ? '0 : s_d;
  end
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_four(logic b);
    b [*4];
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !global_clock_net && !pll_output_zero_pin)
    else $error("output not low after reset");
  a_wr_answer: assert property (s_both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after request");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after request");
  a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_net_gated_off: assert property (s_q.net_off >= 7'h3c |-> !global_clock_net)
    else $error("network clocked while gate off");
  a_pin_gated_off: assert property (s_q.pin_off >= 7'h3c |-> !pll_output_zero_pin)
    else $error("pin clocked while gate off");
  a_net_no_runt: assert property ($rose(global_clock_net) |=> s_four(global_clock_net))
    else $error("short network pulse");
  a_pin_no_runt: assert property ($rose(pll_output_zero_pin) |=> s_four(pll_output_zero_pin))
    else $error("short pin pulse");
endmodule // gcs_properties

bind gcs_top gcs_properties i_gcs_properties (
  .clk, .rst, .global_clock_net, .pll_output_zero_pin, .net_gate_en, .pin_gate_en,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);

`default_nettype wire

//--- dv/gcs_fabric.sv
/*
  gcs_fabric: fabric logic that switches the network source.
  assumes: one request at a time, req pulsed for one cycle while busy is low.
*/
`timescale 1ns/10ps
`default_nettype none

module gcs_fabric (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // request from the bench
  input  wire logic       req,
  input  wire logic [1:0] req_sel,
  input  wire logic       req_gate,
  // towards the block
  output logic [1:0]      clk_select,
  output logic            net_gate_en,
  output logic            busy
);
  int cnt_q;
  assign busy = (cnt_q != 0);
  // gate off, let it drain, switch, let the new source run, then gate
  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= 0;
      clk_select <= 2'h0;
      net_gate_en <= 1'b0;
    end
    else if (req && cnt_q == 0)
    begin
      net_gate_en <= 1'b0;
      cnt_q <= 1;
    end
    else if (cnt_q == 60)
    begin
      clk_select <= req_sel;
      cnt_q <= cnt_q + 1;
    end
    else if (cnt_q == 80)
    begin
      net_gate_en <= req_gate;
      cnt_q <= 0;
    end
    else if (cnt_q != 0)
      cnt_q <= cnt_q + 1;
  end
endmodule // gcs_fabric

`default_nettype wire

//--- dv/global_clock_select_and_gate_tb.sv
/*
  global_clock_select_and_gate_tb: self-checking bench for gcs_top.
  assumes: free-running sources from clk counters, fabric model drives select.
*/
`timescale 1ns/10ps
`default_nettype none

module global_clock_select_and_gate_tb;
  import gcs_pkg::*;
  // ************************************************************
  // stimulus, tasks and sequence
  // ************************************************************
  localparam int W = 600;
  localparam int HP[10] = '{5, 6, 7, 8, 9, 10, 11, 12, 17, 21};
  logic clk = 1'b0, rst = 1'b1, pin_gate_en = 1'b0, f_req = 1'b0, f_gate = 1'b0, gcn, pin, pio, busy;
  logic [1:0] f_sel = 2'h0, sel, bresp, rresp;
  logic [9:0] src = '0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, neten, g_p = 1'b0, p_p = 1'b0;
  int sc[10] = '{default: 0};
  int g_cnt = 0, p_cnt = 0, cycles = 0, error_cnt = 0, checked = 0;
  logic [31:0] seed = 32'hc9277d8e;
  always #5 clk = ~clk;
  gcs_fabric i_gcs_fabric (.clk(clk), .rst(rst), .req(f_req), .req_sel(f_sel), .req_gate(f_gate),
    .clk_select(sel), .net_gate_en(neten), .busy(busy));
  gcs_top i_gcs_top (.clk(clk), .rst(rst), .ded_clk_pin(src[1:0]), .pll_out(src[5:2]),
    .dual_purpose_clock_pin(src[6]), .corner_dual_purpose_clock_pin(src[8:7]), .internal_logic_src(src[9]),
    .clk_select(sel), .net_gate_en(neten), .pin_gate_en(pin_gate_en), .global_clock_net(gcn),
    .pll_output_zero_pin(pin), .pll_input_ok(pio), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // sources, rise counters and the hang guard
  always @(posedge clk)
  begin
    for (int i = 0; i < 10; i++)
    begin
      sc[i] <= (sc[i] == HP[i] - 1) ? 0 : sc[i] + 1;
      src[i] <= src[i] ^ (sc[i] == HP[i] - 1);
    end
    g_p <= gcn;
    p_p <= pin;
    g_cnt <= g_cnt + int'(gcn === 1'b1 && g_p !== 1'b1);
    p_cnt <= p_cnt + int'(pin === 1'b1 && p_p !== 1'b1);
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    logic [31:0] d;
    d = got - exp + 32'(tol);
    checked++;
    if ((d <= 32'(2 * tol)) !== 1'b1)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] exp_r(input int n);
    return (n < 0) ? 32'h0 : 32'(W / (2 * HP[n]));
  endfunction
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha;
    logic hw;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(negedge clk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!(ha | !awvalid) || !(hw | !wvalid));
    do @(negedge clk); while (bvalid !== 1'b1);
    @(posedge clk) bready <= 1'b1;
    @(negedge clk) r = bresp;
    @(posedge clk) bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk) arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    @(posedge clk) rready <= 1'b1;
    @(negedge clk);
    d = rdata;
    r = rresp;
    @(posedge clk) rready <= 1'b0;
  endtask
  task automatic fab(input logic [1:0] s, input logic g);
    @(posedge clk);
    f_sel <= s;
    f_gate <= g;
    f_req <= 1'b1;
    @(posedge clk) f_req <= 1'b0;
    do @(negedge clk); while (busy !== 1'b0);
  endtask
  // gate both off, configure, switch with the fabric, count pulses
  task automatic run_case(input logic [6:0] cfg, input logic [1:0] s, input logic g, input int net, input int pn);
    logic [1:0] r;
    logic [31:0] v;
    int g0;
    int p0;
    pin_gate_en <= 1'b0;
    fab(s, 1'b0);
    axi_wr(GCS_CFG_OFS, {25'h0, cfg}, r);
    fab(s, g);
    // pin enable moves right after a rising edge, like every other input
    @(posedge clk) pin_gate_en <= g;
    repeat (60) @(posedge clk);
    @(negedge clk);
    g0 = g_cnt;
    p0 = p_cnt;
    repeat (W) @(posedge clk);
    @(negedge clk);
    chk(32'(g_cnt - g0), exp_r(net), (net < 0) ? 0 : 1);
    if (pn != -2) chk(32'(p_cnt - p0), exp_r(pn), (pn < 0) ? 0 : 1);
    chk({31'h0, pio}, {31'h0, cfg[0] & (cfg[2:1] == 2'b00)}, 0);
    axi_rd(GCS_STAT_OFS, v, r);
    chk({27'h0, v[4:0]}, {27'h0, cfg[0] & (cfg[2:1] == 2'b00), s, g, g & (net >= 0)}, 0);
  endtask
  initial
  begin : main
    logic [31:0] v;
    logic [1:0] r;
    logic [1:0] rs;
    logic rp;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({30'h0, gcn, pin}, 32'h0, 0);
    axi_rd(GCS_CFG_OFS, v, r);
    chk(v, GCS_CFG_RST, 0);
    axi_rd(32'h0000_0008, v, r);
    chk({30'h0, r}, 32'h0000_0002, 0);
    axi_wr(32'h0000_000c, 32'h0000_0001, r);
    chk({30'h0, r}, 32'h0000_0002, 0);
    axi_wr(GCS_STAT_OFS, 32'hffff_ffff, r);
    chk({30'h0, r}, 32'h0000_0000, 0);
    // lane 0 masked: configuration must stay at its reset value
    wstrb <= 4'he;
    axi_wr(GCS_CFG_OFS, 32'h0000_007f, r);
    wstrb <= 4'hf;
    axi_rd(GCS_CFG_OFS, v, r);
    chk(v, GCS_CFG_RST, 0);
    chk({30'h0, r}, 32'h0000_0000, 0);
    for (int k = 0; k < 4; k++) run_case(7'h01, 2'(k), 1'b1, k, 2);
    run_case(7'h41, 2'h2, 1'b1, 4, 4);
    run_case(7'h41, 2'h3, 1'b1, 5, 4);
    run_case(7'h05, 2'h1, 1'b1, 9, -2);
    for (int k = 0; k < 3; k++) run_case(7'h03 | 7'(k << 4), 2'h0, 1'b1, 6 + k, -2);
    run_case(7'h33, 2'h0, 1'b1, -1, -2);
    run_case(7'h07, 2'h0, 1'b1, -1, -2);
    run_case(7'h09, 2'h0, 1'b1, -1, -2);
    run_case(7'h00, 2'h0, 1'b1, -1, -2);
    run_case(7'h01, 2'h2, 1'b0, -1, -1);
    for (int k = 0; k < 4; k++)
    begin
      rs = 2'($random(seed));
      rp = 1'($random(seed));
      run_case({rp, 6'h01}, rs, 1'b1, int'(rs) + (rs[1] ? 2 * int'(rp) : 0), rp ? 4 : 2);
    end
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({30'h0, gcn, pin}, 32'h0, 0);
    axi_rd(GCS_CFG_OFS, v, r);
    chk(v, GCS_CFG_RST, 0);
    give_verdict();
  end
endmodule // global_clock_select_and_gate_tb

`default_nettype wire
